// ### inc/quad_mode_defines.vh
// constants for the quad-mode entry and exit control block
`ifndef QUAD_MODE_DEFINES_VH
`define QUAD_MODE_DEFINES_VH
// serial instruction codes
`define OP_READ_SR1       8'h05
`define OP_READ_SR2       8'h35
`define OP_WRITE_SR       8'h01
`define OP_QUAD_IO_READ   8'hEB
`define OP_FOUR_ENTER     8'h38
`define OP_FOUR_EXIT      8'hF5
// mode byte after the address of a 0-4-4 read
`define MODE_CONT_NIBBLE  4'hA
`define MODE_EXIT_BYTE    8'h00
`define MODE_RESET_NIB    4'hF
// link edges per phase
`define EDGES_BYTE_SINGLE 4'h8
`define EDGES_BYTE_QUAD   4'h2
`define EDGES_ADDR_MODE   4'h8
// status register bit positions
`define SR1_BUSY_BIT      0
`define SR1_WEL_BIT       1
`define SR1_HI_LSB        2
`define SR2_QEN_BIT       1
// apb byte offsets
`define OFS_CTRL          12'h000
`define OFS_STATE         12'h004
`define OFS_PARAM         12'h038
// control and state register fields
`define CTRL_BUSY_BIT     0
`define STATE_SR1_LSB     0
`define STATE_SR2_LSB     8
`define STATE_CONT_BIT    16
`define STATE_FOUR_BIT    17
// parameter word fields, listed from bit 31 down
`define PW_RFU            8'hFF
`define PW_HOLD_WP_DIS    1'h0
`define PW_QEN_REQ        3'h5
`define PW_ENTRY          4'hD
`define PW_EXIT           6'h3D
`define PW_SUPPORTED      1'h1
`define PW_FOUR_ON        5'h02
`define PW_FOUR_OFF       4'h2
// reset values
`define BUSY_RST          1'h0
`define SR1_HI_RST        6'h00
`define QEN_RST           1'h0
`define SYNC_RST          6'h20
`endif

// ### src/pin_sync.v
// three-stage synchroniser per pin; output follows once stages two and three agree
module pin_sync #(
   parameter W   = 6,
   parameter RST = 6'h20
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   reg [W-1:0] q_q;
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q[i] <= RST[i];
               s2_q[i] <= RST[i];
               s3_q[i] <= RST[i];
               q_q[i]  <= RST[i];
            end else begin
               s1_q[i] <= d[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i]) begin
                  q_q[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate
   assign q = q_q;
endmodule

// ### src/byte_shift.v
// link input shifter: one or four bits per link edge into a byte
module byte_shift (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       shift,
   input  wire       wide,
   input  wire [3:0] d,
   output wire [7:0] byte_q,
   output wire [7:0] byte_d
);
   reg [7:0] sh_q;
   assign byte_d = wide ? {sh_q[3:0], d} : {sh_q[6:0], d[0]};
   assign byte_q = sh_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= 8'h00;
      end else if (shift) begin
         sh_q <= byte_d;
      end
   end
endmodule

// ### src/quad_mode_entry_exit_control.v
// quad-mode entry and exit control: serial decode, status registers, apb view
//
// Functional notes
// - quad-enable flag sits at bit 1 of the second status register.
// - instruction 05h returns the first status register.
// - instruction 35h returns the second status register holding quad-enable.
// - instruction 01h with two bytes loads quad-enable from bit 1 of byte two.
// - mode byte with upper nibble A keeps continuous 0-4-4 read; needs quad-enable.
// - mode byte 00h ends continuous 0-4-4 read at the end of that read.
// - Fh on all four lines for 8 clocks ends continuous 0-4-4 read.
// - instruction 38h switches to four-line instruction, address and data.
// - instruction F5h returns from four-line command mode to single line.
// - hold and write-protect cannot be disabled; parameter bit 23 reads 0.
// - parameter bits 22:20 read 101b, the quad-enable requirement code.
// - parameter bits 19:16 read 1101b, the 0-4-4 entry methods.
// - parameter bits 15:10 read 111101, the 0-4-4 exit methods.
// - parameter bit 9 reads 1, continuous 0-4-4 read supported.
// - parameter bits 31:24 read all ones.
// - host polls busy at bit 0 of the first status register.
//
// Design decision made here: the APB register port.
`include "quad_mode_defines.vh"
module quad_mode_entry_exit_control (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        sck,
   input  wire        cs_n,
   input  wire [3:0]  quad_data_lines_in,
   output wire [3:0]  quad_data_lines_out,
   output wire [3:0]  quad_data_lines_oe,
   output wire        quad_enable_flag,
   output wire        four_line_command_mode,
   output wire        cont_read_mode,
   output wire        write_in_progress_flag
);
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_CMD  = 6'h02;
   localparam [5:0] ST_ADDR = 6'h04;
   localparam [5:0] ST_WR   = 6'h08;
   localparam [5:0] ST_OUT  = 6'h10;
   localparam [5:0] ST_SKIP = 6'h20;

   wire [5:0]  pins_s;
   wire        cs_s;
   wire        sck_s;
   wire [3:0]  dq_s;
   wire [7:0]  sh_d;
   wire        wide;
   wire        sck_rise;
   wire        sck_fall;
   wire        cs_fall;
   wire        cs_rise;
   wire [3:0]  byte_edges;
   wire        byte_last;
   wire        apb_acc;
   wire        apb_wr;
   wire [31:0] param_word;
   wire [31:0] state_word;

   reg  [5:0]  st_q;
   reg  [3:0]  cnt_q;
   reg         sck_q;
   reg         cs_q;
   reg         qen_q;
   reg  [5:0]  sr1_hi_q;
   reg         four_q;
   reg         cont_q;
   reg         cont_next_q;
   reg         addr_done_q;
   reg         all_f_q;
   reg         pend_four_on_q;
   reg         pend_four_off_q;
   reg  [1:0]  wr_cnt_q;
   reg  [7:0]  wr_b0_q;
   reg  [7:0]  wr_b1_q;
   reg         sel_sr2_q;
   reg  [7:0]  out_q;
   reg  [3:0]  dout_q;
   reg  [3:0]  doe_q;
   reg         busy_q;
   reg         pready_q;
   reg         pslverr_q;
   reg  [31:0] prdata_q;
   reg  [7:0]  sr1_val;
   reg  [7:0]  sr2_val;
   reg  [7:0]  stat_val;

   // link pins are asynchronous to pclk; sck is oversampled, not used as a clock
   pin_sync #(
      .W   (6),
      .RST (`SYNC_RST)
   ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({cs_n, sck, quad_data_lines_in}),
      .q     (pins_s)
   );

   assign cs_s  = pins_s[5];
   assign sck_s = pins_s[4];
   assign dq_s  = pins_s[3:0];

   // sck edges are only taken while the chip is selected
   assign sck_rise = sck_s & ~sck_q & ~cs_s;
   assign sck_fall = ~sck_s & sck_q & ~cs_s;
   assign cs_fall  = ~cs_s & cs_q;
   assign cs_rise  = cs_s & ~cs_q;

   // four lines in four-line command mode and in every 0-4-4 address phase
   assign wide       = four_q | st_q[2];
   assign byte_edges = wide ? `EDGES_BYTE_QUAD : `EDGES_BYTE_SINGLE;
   assign byte_last  = (cnt_q == (byte_edges - 4'h1));

   byte_shift u_shift (
      .clk    (pclk),
      .rst_n  (presetn),
      .shift  (sck_rise),
      .wide   (wide),
      .d      (dq_s),
      .byte_q (),
      .byte_d (sh_d)
   );

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_q <= 1'b0;
         cs_q  <= 1'b1;
      end else begin
         sck_q <= sck_s;
         cs_q  <= cs_s;
      end
   end

   // live status bytes, resampled whenever a new byte is loaded for output
   always @* begin
      sr1_val = {sr1_hi_q, 2'b00};
      sr1_val[`SR1_BUSY_BIT] = busy_q;
      sr1_val[`SR1_WEL_BIT] = 1'b0;
      sr2_val = 8'h00;
      sr2_val[`SR2_QEN_BIT] = qen_q;
      stat_val = sel_sr2_q ? sr2_val : sr1_val;
   end

   // serial transaction state machine
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q           <= ST_IDLE;
         cnt_q          <= 4'h0;
         qen_q          <= `QEN_RST;
         sr1_hi_q       <= `SR1_HI_RST;
         four_q         <= 1'b0;
         cont_q         <= 1'b0;
         cont_next_q    <= 1'b0;
         addr_done_q    <= 1'b0;
         all_f_q        <= 1'b0;
         pend_four_on_q  <= 1'b0;
         pend_four_off_q <= 1'b0;
         wr_cnt_q       <= 2'h0;
         wr_b0_q        <= 8'h00;
         wr_b1_q        <= 8'h00;
         sel_sr2_q      <= 1'b0;
         out_q          <= 8'h00;
         dout_q         <= 4'h0;
         doe_q          <= 4'h0;
      end else if (cs_rise) begin
         // every mode change is committed when the host deselects
         st_q  <= ST_IDLE;
         doe_q <= 4'h0;
         if (pend_four_on_q) begin
            four_q <= 1'b1;
         end
         if (pend_four_off_q) begin
            four_q <= 1'b0;
         end
         if (addr_done_q) begin
            cont_q <= cont_next_q;
         end
         // a truncated byte or a third byte voids the write
         if (st_q[3] && wr_cnt_q == 2'h2 && cnt_q == 4'h0) begin
            sr1_hi_q <= wr_b0_q[7:`SR1_HI_LSB];
            qen_q    <= wr_b1_q[`SR2_QEN_BIT];
         end
      end else if (cs_fall) begin
         cnt_q          <= 4'h0;
         addr_done_q    <= 1'b0;
         all_f_q        <= 1'b1;
         pend_four_on_q  <= 1'b0;
         pend_four_off_q <= 1'b0;
         wr_cnt_q       <= 2'h0;
         doe_q          <= 4'h0;
         // no instruction byte while continuous read is armed
         st_q <= cont_q ? ST_ADDR : ST_CMD;
      end else begin
         case (st_q)
            ST_CMD: begin
               if (sck_rise) begin
                  cnt_q <= byte_last ? 4'h0 : cnt_q + 4'h1;
                  if (byte_last) begin
                     st_q <= ST_SKIP;
                     case (sh_d)
                        `OP_READ_SR1: begin
                           sel_sr2_q <= 1'b0;
                           out_q     <= sr1_val;
                           st_q      <= ST_OUT;
                        end
                        `OP_READ_SR2: begin
                           sel_sr2_q <= 1'b1;
                           out_q     <= sr2_val;
                           st_q      <= ST_OUT;
                        end
                        `OP_WRITE_SR: begin
                           // status writes are ignored while the array is busy
                           if (!busy_q) begin
                              st_q <= ST_WR;
                           end
                        end
                        `OP_QUAD_IO_READ: begin
                           if (qen_q) begin
                              st_q <= ST_ADDR;
                           end
                        end
                        `OP_FOUR_ENTER: begin
                           pend_four_on_q <= ~four_q;
                        end
                        `OP_FOUR_EXIT: begin
                           pend_four_off_q <= four_q;
                        end
                        default: begin
                           st_q <= ST_SKIP;
                        end
                     endcase
                  end
               end
            end
            ST_ADDR: begin
               // six address nibbles then the two nibbles of the mode byte
               if (sck_rise) begin
                  cnt_q <= cnt_q + 4'h1;
                  if (dq_s != `MODE_RESET_NIB) begin
                     all_f_q <= 1'b0;
                  end
                  if (cnt_q == (`EDGES_ADDR_MODE - 4'h1)) begin
                     addr_done_q <= 1'b1;
                     st_q        <= ST_SKIP;
                     if (all_f_q && dq_s == `MODE_RESET_NIB) begin
                        cont_next_q <= 1'b0;
                     end else if (sh_d[7:4] == `MODE_CONT_NIBBLE) begin
                        cont_next_q <= qen_q;
                     end else if (sh_d == `MODE_EXIT_BYTE) begin
                        cont_next_q <= 1'b0;
                     end else begin
                        cont_next_q <= 1'b0;
                     end
                  end
               end
            end
            ST_WR: begin
               if (sck_rise) begin
                  cnt_q <= byte_last ? 4'h0 : cnt_q + 4'h1;
                  if (byte_last) begin
                     if (wr_cnt_q == 2'h0) begin
                        wr_b0_q <= sh_d;
                     end
                     if (wr_cnt_q == 2'h1) begin
                        wr_b1_q <= sh_d;
                     end
                     if (wr_cnt_q != 2'h3) begin
                        wr_cnt_q <= wr_cnt_q + 2'h1;
                     end
                  end
               end
            end
            ST_OUT: begin
               // mode 0: the msb appears at the fall after the last opcode edge,
               // so that fall must load, not shift, or the host loses bit 7
               if (sck_fall && doe_q == 4'h0) begin
                  doe_q  <= four_q ? 4'hF : 4'h2;
                  dout_q <= four_q ? out_q[7:4] : {2'b00, out_q[7], 1'b0};
               end else if (sck_fall) begin
                  cnt_q <= byte_last ? 4'h0 : cnt_q + 4'h1;
                  if (byte_last) begin
                     // repeated reads of a status byte track the live value
                     out_q  <= stat_val;
                     dout_q <= four_q ? stat_val[7:4] : {2'b00, stat_val[7], 1'b0};
                  end else if (four_q) begin
                     out_q  <= {out_q[3:0], 4'h0};
                     dout_q <= out_q[3:0];
                  end else begin
                     out_q  <= {out_q[6:0], 1'b0};
                     dout_q <= {2'b00, out_q[6], 1'b0};
                  end
               end
            end
            ST_SKIP: begin
               st_q <= ST_SKIP;
            end
            ST_IDLE: begin
               st_q <= ST_IDLE;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // fixed discoverable parameter word
   assign param_word = {
      `PW_RFU,
      `PW_HOLD_WP_DIS,
      `PW_QEN_REQ,
      `PW_ENTRY,
      `PW_EXIT,
      `PW_SUPPORTED,
      `PW_FOUR_ON,
      `PW_FOUR_OFF
   };

   assign state_word = {14'h0000, four_q, cont_q, sr2_val, sr1_val};

   // apb slave: one wait state, so pready is a plain flop
   assign apb_acc = psel & penable & ~pready_q;
   assign apb_wr  = psel & penable & pready_q & pwrite;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
         busy_q    <= `BUSY_RST;
      end else begin
         pready_q <= apb_acc;
         if (apb_acc) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
            case (paddr)
               `OFS_CTRL: begin
                  if (!pwrite) begin
                     prdata_q <= {31'h00000000, busy_q};
                  end
               end
               `OFS_STATE: begin
                  if (pwrite) begin
                     pslverr_q <= 1'b1;
                  end else begin
                     prdata_q <= state_word;
                  end
               end
               `OFS_PARAM: begin
                  if (pwrite) begin
                     pslverr_q <= 1'b1;
                  end else begin
                     prdata_q <= param_word;
                  end
               end
               default: begin
                  pslverr_q <= 1'b1;
               end
            endcase
         end
         // a write lands at the edge where pready is seen high
         if (apb_wr && paddr == `OFS_CTRL) begin
            busy_q <= pwdata[`CTRL_BUSY_BIT];
         end
      end
   end

   assign prdata                 = prdata_q;
   assign pready                 = pready_q;
   assign pslverr                = pslverr_q;
   assign quad_data_lines_out    = dout_q;
   assign quad_data_lines_oe     = doe_q;
   assign quad_enable_flag       = qen_q;
   assign four_line_command_mode = four_q;
   assign cont_read_mode         = cont_q;
   assign write_in_progress_flag = busy_q;

endmodule

// ### verif/quad_mode_entry_exit_control_chk.sv
// port-level assertion checker for the quad-mode control block
module quad_mode_entry_exit_control_chk (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        cs_n,
   input logic [3:0]  quad_data_lines_oe,
   input logic        quad_enable_flag,
   input logic        four_line_command_mode,
   input logic        cont_read_mode,
   input logic        write_in_progress_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ctrl_wr_q;
   logic wbit_q;
   logic mapped;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   assign mapped = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h038;
   // remember the control write so the flag can be compared one cycle on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_wr_q <= 1'b0;
         wbit_q    <= 1'b0;
      end else begin
         ctrl_wr_q <= pready && pwrite && paddr == 12'h000;
         wbit_q    <= pwdata[0];
      end
   end
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_cs_idle;
      cs_n [*8];
   endsequence
   a_one_wait:
      assert property (s_wait |=> pready)
      else $error("pready not one cycle after access");
   a_pready_pulse:
      assert property (pready |=> !pready)
      else $error("pready held high");
   a_param_word:
      assert property (pready && !pwrite && paddr == 12'h038 |->
         prdata == 32'hFF5DF622 && !pslverr)
      else $error("parameter word wrong");
   a_unmapped_err:
      assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_ro_write:
      assert property (pready && pwrite && paddr != 12'h000 |-> pslverr)
      else $error("read-only write not refused");
   a_busy_write:
      assert property (ctrl_wr_q |-> write_in_progress_flag == wbit_q)
      else $error("busy flag not loaded");
   a_busy_hold:
      assert property (!ctrl_wr_q |-> $stable(write_in_progress_flag))
      else $error("busy flag changed unasked");
   a_mode_commit:
      assert property (!$stable(quad_enable_flag) || !$stable(cont_read_mode)
         || !$stable(four_line_command_mode) |-> cs_n)
      else $error("mode changed inside a frame");
   a_qen_cont:
      assert property ($rose(cont_read_mode) |-> quad_enable_flag)
      else $error("continuous mode without quad enable");
   a_oe_idle:
      assert property (s_cs_idle |-> quad_data_lines_oe == 4'h0)
      else $error("lines driven while deselected");
endmodule
bind quad_mode_entry_exit_control quad_mode_entry_exit_control_chk chk_u (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .cs_n, .quad_data_lines_oe, .quad_enable_flag,
   .four_line_command_mode, .cont_read_mode, .write_in_progress_flag
);

// ### verif/spi_host_model.sv
// host-side serial flash controller model driving the link pins
module spi_host_model (
   input  wire logic [3:0] dq_out,
   input  wire logic [3:0] dq_oe,
   output logic            sck,
   output logic            cs_n,
   output logic [3:0]      dq_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rd_q;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      dq_in = 4'hF;
   end
   // sck idles low between frames; data set on the low phase
   task automatic edge_out(input logic [3:0] v);
      dq_in = v;
      #80 sck = 1'b1;
      // an undriven line shows the inverse of its last level, never stale data
      rd_q = {rd_q[6:0], dq_oe[1] ? dq_out[1] : ~dq_out[1]};
      #80 sck = 1'b0;
   endtask
   task automatic frame_begin();
      cs_n = 1'b0;
   endtask
   // released lines flip so a stale level is never mistaken for data
   task automatic frame_end();
      #40 cs_n = 1'b1;
      dq_in = ~dq_in;
      #200;
   endtask
   task automatic send1(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         edge_out({~dq_in[3:1], b[i]});
   endtask
   task automatic send4(input logic [7:0] b);
      edge_out(b[7:4]);
      edge_out(b[3:0]);
   endtask
   task automatic recv1();
      for (int i = 0; i < 8; i++)
         edge_out(~dq_in);
   endtask
endmodule

// ### verif/quad_mode_entry_exit_control_tb_top.sv
// self-checking bench for the quad-mode entry and exit control block
module quad_mode_entry_exit_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sck;
   logic        cs_n;
   logic [3:0]  dq_in;
   logic [3:0]  dq_out;
   logic [3:0]  dq_oe;
   logic        quad_en;
   logic        fl;
   logic        cr;
   logic        busy;
   logic [31:0] rd;
   logic        err_b;
   int          err_total;
   int          total_checks;
   quad_mode_entry_exit_control dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n),
      .quad_data_lines_in(dq_in), .quad_data_lines_out(dq_out),
      .quad_data_lines_oe(dq_oe), .quad_enable_flag(quad_en),
      .four_line_command_mode(fl), .cont_read_mode(cr),
      .write_in_progress_flag(busy)
   );
   spi_host_model host_u (
      .dq_out(dq_out), .dq_oe(dq_oe), .sck(sck), .cs_n(cs_n), .dq_in(dq_in)
   );
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic results();
      if (err_total == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err_b = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50)
         chk(32'h0, 32'h1);
      #1;
   endtask
   task automatic status(input logic [7:0] op);
      host_u.frame_begin();
      host_u.send1(op);
      host_u.recv1();
      host_u.frame_end();
   endtask
   task automatic wrsr(input logic [7:0] b1, input logic [7:0] b2);
      host_u.frame_begin();
      host_u.send1(8'h01);
      host_u.send1(b1);
      host_u.send1(b2);
      host_u.frame_end();
   endtask
   // without an opcode the frame opens straight with the address nibbles
   task automatic cont(input logic op, input logic [7:0] m);
      host_u.frame_begin();
      if (op)
         host_u.send1(8'hEB);
      repeat (3) host_u.send4(m == 8'hFF ? 8'hFF : 8'h3C);
      host_u.send4(m);
      host_u.frame_end();
   endtask
   task automatic t_regs();
      apb(1'b0, 12'h038, 32'h0);
      chk(rd, 32'hFF5DF622);
      apb(1'b1, 12'h038, 32'h0);
      chk(err_b, 1'h1);
      apb(1'b0, 12'h038, 32'h0);
      chk({rd[31:24], err_b}, 9'h1FE);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk(err_b, 1'h1);
   endtask
   task automatic t_status();
      apb(1'b1, 12'h000, 32'h1);
      chk(busy, 1'h1);
      status(8'h05);
      chk(host_u.rd_q, 8'h01);
      wrsr(8'h00, 8'h02);
      chk(quad_en, 1'h0);
      apb(1'b1, 12'h000, 32'h0);
      status(8'h05);
      chk(host_u.rd_q, 8'h00);
      cont(1'b1, 8'hA5);
      chk(cr, 1'h0);
   endtask
   task automatic t_quad_enable();
      wrsr(8'hA4, 8'h02);
      chk(quad_en, 1'h1);
      status(8'h35);
      chk(host_u.rd_q, 8'h02);
      status(8'h05);
      chk(host_u.rd_q, 8'hA4);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[15:8], 8'h02);
   endtask
   task automatic t_cont();
      cont(1'b1, 8'hA5);
      chk(cr, 1'h1);
      cont(1'b0, 8'hA3);
      chk(cr, 1'h1);
      cont(1'b0, 8'h00);
      chk(cr, 1'h0);
      cont(1'b1, 8'hAF);
      chk(cr, 1'h1);
      cont(1'b0, 8'hFF);
      chk(cr, 1'h0);
   endtask
   task automatic t_four_line();
      host_u.frame_begin();
      host_u.send1(8'h38);
      host_u.frame_end();
      chk(fl, 1'h1);
      host_u.frame_begin();
      host_u.send4(8'h38);
      host_u.frame_end();
      chk(fl, 1'h1);
      host_u.frame_begin();
      host_u.send4(8'hF5);
      host_u.frame_end();
      chk(fl, 1'h0);
      wrsr(8'h00, 8'h00);
      chk(quad_en, 1'h0);
   endtask
   initial begin
      #150000;
      err_total++;
      results();
   end
   initial begin
      err_total = 0;
      total_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      t_regs();
      t_status();
      t_quad_enable();
      t_cont();
      t_four_line();
      results();
   end
endmodule
